//--- verilog/dmaac_core.sv
// Two-, four- or eight-channel (eight by default) DMA pointer and byte count engine with its register slave.
`timescale 1ns/1ps
`include "dmaac_params.svh"
module dmaac_core #(
   parameter int CHANNELS = 8,
   parameter int FIFO_DEPTH = `DMAAC_FIFO_DEPTH
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output dmaac_pkg::dmaac_bus_req_s mem_req_out,
   input wire logic mem_waitrequest_in,
   input wire logic [31:0] mem_readdata_in,
   input wire logic [CHANNELS-1:0] dma_request_in,
   output logic [CHANNELS-1:0] channel_acknowledge_out
);
   localparam int CW = $clog2(CHANNELS);

   if (CHANNELS < 2 || CHANNELS > 8 || (1 << CW) != CHANNELS)
   begin : g_chan_check
      $error("dmaac_core supports two, four or eight channels");
   end

   // Pointers and counts have no reset: software loads them before a start.
   logic [31:0] source_pointer [CHANNELS];
   logic [31:0] destination_pointer [CHANNELS];
   logic [`DMAAC_COUNT_MSB:0] remaining_bytes [CHANNELS];
   logic [5:0] pointer_step_control [CHANNELS];
   dmaac_pkg::dmaac_chan_ctrl_s chan_ctrl_q [CHANNELS];
   logic [CHANNELS-1:0] done_q;
   logic [CHANNELS-1:0] burst_q;

   dmaac_pkg::dmaac_state_e state_q;
   logic [CW-1:0] cur_q;
   logic [31:0] holding_register_q;
   logic [31:0] avs_readdata_q;
   logic avs_wait_q;

   logic [2:0] reg_sel;
   logic [CW-1:0] reg_chan;
   logic reg_hit;
   logic sw_wr;
   logic sw_rd;
   logic [CHANNELS-1:0] eligible;
   logic any_eligible;
   logic [CW-1:0] pick;
   logic xfer_done;
   logic last_xfer;
   logic [`DMAAC_COUNT_MSB:0] count_next;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [31:0] fifo_out_data;
   logic fifo_push;
   logic fifo_pop;

   function automatic logic [`DMAAC_COUNT_MSB:0] size_bytes(input logic [1:0] size);
      case (size)
         dmaac_pkg::SZ_BYTE: size_bytes = (`DMAAC_COUNT_MSB + 1)'(1);
         dmaac_pkg::SZ_HALF: size_bytes = (`DMAAC_COUNT_MSB + 1)'(2);
         default: size_bytes = (`DMAAC_COUNT_MSB + 1)'(4);
      endcase
   endfunction : size_bytes

   // The step is the size scaled to the counting bit, so lower bits never move.
   function automatic logic [31:0] step_pointer(input logic [31:0] ptr,
                                                input logic [1:0] dir,
                                                input logic [1:0] size,
                                                input logic [2:0] mode);
      logic [31:0] step;
      step = 32'(size_bytes(size)) << (5'(mode) * 5'(`DMAAC_MODE_SHIFT));
      case (dir)
         dmaac_pkg::DIR_UP: step_pointer = ptr + step;
         dmaac_pkg::DIR_DOWN: step_pointer = ptr - step;
         default: step_pointer = ptr;
      endcase
   endfunction : step_pointer

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] be);
      merge_bytes = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
         begin
            merge_bytes[8*b +: 8] = new_v[8*b +: 8];
         end
      end
   endfunction : merge_bytes

   function automatic logic [3:0] lane_mask(input logic [1:0] lane, input logic [1:0] size);
      case (size)
         dmaac_pkg::SZ_BYTE: lane_mask = 4'h1 << lane;
         dmaac_pkg::SZ_HALF: lane_mask = lane[1] ? 4'hC : 4'h3;
         default: lane_mask = 4'hF;
      endcase
   endfunction : lane_mask

   assign reg_sel = avs_address_in[4:2];
   assign reg_chan = avs_address_in[`DMAAC_CH_STRIDE_LSB +: CW];
   assign reg_hit = reg_sel <= `DMAAC_OFS_CHAN_STAT
                    && 4'(avs_address_in[7:`DMAAC_CH_STRIDE_LSB]) < 4'(CHANNELS);
   // A write is taken on the edge where waitrequest is already low; a read one edge earlier, while it is still high.
   assign sw_wr = avs_write_in && !avs_wait_q && reg_hit;
   assign sw_rd = avs_read_in && avs_wait_q;

   always_comb
   begin
      for (int c = 0; c < CHANNELS; c++)
      begin
         eligible[c] = chan_ctrl_q[c].start && !channel_acknowledge_out[c]
                       && (dma_request_in[c] || burst_q[c]);
      end
   end

   always_comb
   begin
      pick = '0;
      for (int c = CHANNELS - 1; c >= 0; c--)
      begin
         if (eligible[c])
         begin
            pick = CW'(c);
         end
      end
   end

   assign any_eligible = |eligible;
   assign xfer_done = state_q == dmaac_pkg::ST_WRITE && !mem_waitrequest_in;
   assign count_next = remaining_bytes[cur_q] > size_bytes(chan_ctrl_q[cur_q].size)
                       ? remaining_bytes[cur_q] - size_bytes(chan_ctrl_q[cur_q].size)
                       : '0;
   assign last_xfer = count_next == '0;
   assign fifo_push = state_q == dmaac_pkg::ST_READ && !mem_waitrequest_in;
   assign fifo_pop = state_q == dmaac_pkg::ST_LOAD && fifo_out_valid;

   dmaac_fifo #(
      .WIDTH(32),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(fifo_push),
      .in_ready_out(fifo_in_ready),
      .in_data_in(mem_readdata_in >> (8 * source_pointer[cur_q][1:0])),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(state_q == dmaac_pkg::ST_LOAD),
      .out_data_out(fifo_out_data)
   );

   // Register slave: one wait cycle, then the answer with waitrequest low.
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         avs_wait_q <= 1'b1;
         avs_readdata_q <= 32'h0000_0000;
      end
      else
      begin
         avs_wait_q <= !((avs_read_in || avs_write_in) && avs_wait_q);
         if (sw_rd)
         begin
            avs_readdata_q <= 32'h0000_0000;
            if (reg_hit)
            begin
               case (reg_sel)
                  `DMAAC_OFS_SRC_PTR: avs_readdata_q <= source_pointer[reg_chan];
                  `DMAAC_OFS_DST_PTR: avs_readdata_q <= destination_pointer[reg_chan];
                  `DMAAC_OFS_REMAIN: avs_readdata_q <= 32'(remaining_bytes[reg_chan]);
                  `DMAAC_OFS_STEP_CTRL: avs_readdata_q <= 32'(pointer_step_control[reg_chan]);
                  `DMAAC_OFS_CHAN_CTRL: avs_readdata_q <= 32'(chan_ctrl_q[reg_chan]);
                  default: avs_readdata_q <= {30'h0000_0000,
                     state_q != dmaac_pkg::ST_IDLE && cur_q == reg_chan,
                     done_q[reg_chan]};
               endcase
            end
         end
      end
   end

   // Engine updates win over a software write landing in the same cycle.
   always_ff @(posedge core_clk_in)
   begin
      if (xfer_done)
      begin
         source_pointer[cur_q] <= step_pointer(source_pointer[cur_q],
            chan_ctrl_q[cur_q].src_dir, chan_ctrl_q[cur_q].size,
            pointer_step_control[cur_q][`DMAAC_SCM_LSB +: 3]);
         destination_pointer[cur_q] <= step_pointer(destination_pointer[cur_q],
            chan_ctrl_q[cur_q].dst_dir, chan_ctrl_q[cur_q].size,
            pointer_step_control[cur_q][`DMAAC_DCM_LSB +: 3]);
         remaining_bytes[cur_q] <= count_next;
      end
      if (sw_wr && !(xfer_done && reg_chan == cur_q))
      begin
         case (reg_sel)
            `DMAAC_OFS_SRC_PTR: source_pointer[reg_chan] <=
               merge_bytes(source_pointer[reg_chan], avs_writedata_in, avs_byteenable_in);
            `DMAAC_OFS_DST_PTR: destination_pointer[reg_chan] <=
               merge_bytes(destination_pointer[reg_chan], avs_writedata_in, avs_byteenable_in);
            `DMAAC_OFS_REMAIN: remaining_bytes[reg_chan] <=
               (`DMAAC_COUNT_MSB + 1)'(merge_bytes(32'(remaining_bytes[reg_chan]),
                  avs_writedata_in, avs_byteenable_in));
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         for (int c = 0; c < CHANNELS; c++)
         begin
            pointer_step_control[c] <= 6'(`DMAAC_CTRL_RESET);
            chan_ctrl_q[c] <= 8'(`DMAAC_CTRL_RESET);
         end
         done_q <= '0;
      end
      else
      begin
         if (sw_wr && reg_sel == `DMAAC_OFS_STEP_CTRL && avs_byteenable_in[0])
         begin
            pointer_step_control[reg_chan] <= avs_writedata_in[5:0];
         end
         if (sw_wr && reg_sel == `DMAAC_OFS_CHAN_CTRL && avs_byteenable_in[0])
         begin
            chan_ctrl_q[reg_chan] <= avs_writedata_in[7:0];
         end
         if (sw_wr && reg_sel == `DMAAC_OFS_CHAN_STAT && avs_byteenable_in[0]
             && avs_writedata_in[`DMAAC_ST_DONE])
         begin
            done_q[reg_chan] <= 1'b0;
         end
         if (xfer_done && last_xfer)
         begin
            chan_ctrl_q[cur_q].start <= 1'b0;
            done_q[cur_q] <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         burst_q <= '0;
         channel_acknowledge_out <= '0;
      end
      else
      begin
         channel_acknowledge_out <= '0;
         if (xfer_done)
         begin
            burst_q[cur_q] <= chan_ctrl_q[cur_q].m2m && !last_xfer;
            if (!chan_ctrl_q[cur_q].m2m || last_xfer)
            begin
               channel_acknowledge_out[cur_q] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_q <= dmaac_pkg::ST_IDLE;
         cur_q <= '0;
         holding_register_q <= 32'h0000_0000;
         mem_req_out <= '0;
      end
      else
      begin
         case (state_q)
            dmaac_pkg::ST_IDLE:
            begin
               if (any_eligible && fifo_in_ready)
               begin
                  cur_q <= pick;
                  mem_req_out.read <= 1'b1;
                  mem_req_out.address <= source_pointer[pick];
                  mem_req_out.byteenable <= lane_mask(source_pointer[pick][1:0],
                                                      chan_ctrl_q[pick].size);
                  state_q <= dmaac_pkg::ST_READ;
               end
            end
            dmaac_pkg::ST_READ:
            begin
               if (!mem_waitrequest_in)
               begin
                  mem_req_out.read <= 1'b0;
                  state_q <= dmaac_pkg::ST_LOAD;
               end
            end
            dmaac_pkg::ST_LOAD:
            begin
               if (fifo_pop)
               begin
                  holding_register_q <= fifo_out_data;
                  mem_req_out.write <= 1'b1;
                  mem_req_out.address <= destination_pointer[cur_q];
                  mem_req_out.writedata <= fifo_out_data << (8 * destination_pointer[cur_q][1:0]);
                  mem_req_out.byteenable <= lane_mask(destination_pointer[cur_q][1:0],
                                                      chan_ctrl_q[cur_q].size);
                  state_q <= dmaac_pkg::ST_WRITE;
               end
            end
            dmaac_pkg::ST_WRITE:
            begin
               if (!mem_waitrequest_in)
               begin
                  mem_req_out.write <= 1'b0;
                  state_q <= dmaac_pkg::ST_IDLE;
               end
            end
            default: state_q <= dmaac_pkg::ST_IDLE;
         endcase
      end
   end

   assign avs_readdata_out = avs_readdata_q;
   assign avs_waitrequest_out = avs_wait_q;
endmodule : dmaac_core

//--- verilog/dmaac_params.svh
// Constants of the DMA channel address and count block.
`ifndef DMAAC_PARAMS_SVH
`define DMAAC_PARAMS_SVH
`define DMAAC_CH_STRIDE_LSB 5
`define DMAAC_OFS_SRC_PTR 3'h0
`define DMAAC_OFS_DST_PTR 3'h1
`define DMAAC_OFS_REMAIN 3'h2
`define DMAAC_OFS_STEP_CTRL 3'h3
`define DMAAC_OFS_CHAN_CTRL 3'h4
`define DMAAC_OFS_CHAN_STAT 3'h5
`define DMAAC_COUNT_MSB 23
`define DMAAC_SCM_LSB 0
`define DMAAC_DCM_LSB 3
`define DMAAC_CC_START 0
`define DMAAC_CC_M2M 1
`define DMAAC_CC_SIZE_LSB 2
`define DMAAC_CC_SDIR_LSB 4
`define DMAAC_CC_DDIR_LSB 6
`define DMAAC_ST_DONE 0
`define DMAAC_ST_ACTIVE 1
`define DMAAC_CTRL_RESET 32'h0000_0000
`define DMAAC_MODE_SHIFT 3'h4
`define DMAAC_FIFO_DEPTH 8
`endif

//--- verilog/dmaac_pkg.sv
// Types shared by the DMA channel address and count block.
package dmaac_pkg;
   typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_WORD = 2'h2} dmaac_size_e;
   typedef enum logic [1:0] {DIR_UP = 2'h0, DIR_DOWN = 2'h1, DIR_HOLD = 2'h2} dmaac_dir_e;
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_LOAD = 2'b11,
      ST_WRITE = 2'b10
   } dmaac_state_e;
   typedef struct packed
   {
      logic read;
      logic write;
      logic [31:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } dmaac_bus_req_s;
   typedef struct packed
   {
      logic [1:0] dst_dir;
      logic [1:0] src_dir;
      logic [1:0] size;
      logic m2m;
      logic start;
   } dmaac_chan_ctrl_s;
endpackage : dmaac_pkg

//--- verilog/dmaac_fifo.sv
// Word FIFO that carries read data toward the holding register.
`timescale 1ns/1ps
module dmaac_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic push;
   logic pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin : g_depth_check
      $error("dmaac_fifo depth must be a power of two of at least two");
   end

   assign in_ready_out = (wr_q - rd_q) != (AW + 1)'(DEPTH);
   assign out_valid_out = wr_q != rd_q;
   assign out_data_out = mem[rd_q[AW-1:0]];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   always_ff @(posedge core_clk_in)
   begin
      if (push)
      begin
         mem[wr_q[AW-1:0]] <= in_data_in;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule : dmaac_fifo

//--- bench/dmaac_core_properties.sv
// Port-level checks on the DMA channel address and count core.
`timescale 1ns/1ps
module dmaac_core_checker #(
   parameter int CHANNELS = 8
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire dmaac_pkg::dmaac_bus_req_s mem_req_out,
   input wire logic mem_waitrequest_in,
   input wire logic [CHANNELS-1:0] channel_acknowledge_out
);
   logic wr_fin;
   logic any_ack;
   assign wr_fin = mem_req_out.write && !mem_waitrequest_in;
   assign any_ack = |channel_acknowledge_out;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   reg_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out) else $error("register request not answered in one cycle");
   wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest low for more than one cycle");
   unmapped_zero_a: assert property (
      avs_read_in && !avs_waitrequest_out && avs_address_in[4:3] == 2'b11
      |-> avs_readdata_out == 32'h0000_0000) else $error("unmapped read not zero");
   bus_hold_a: assert property (
      (mem_req_out.read || mem_req_out.write) && mem_waitrequest_in |=> $stable(mem_req_out))
      else $error("system bus request changed while stalled");
   one_dir_a: assert property (!(mem_req_out.read && mem_req_out.write))
      else $error("read and write issued together");
   read_then_write_a: assert property (
      $fell(mem_req_out.read) |-> ##[1:3] mem_req_out.write)
      else $error("source read not followed by destination write");
   write_lanes_a: assert property (mem_req_out.write |-> mem_req_out.byteenable inside
      {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF}) else $error("byte lanes do not fit a size");
   ack_pulse_a: assert property (
      any_ack |=> (channel_acknowledge_out & $past(channel_acknowledge_out)) == '0)
      else $error("acknowledge longer than one cycle");
   ack_after_write_a: assert property (
      $rose(any_ack) |-> $past(wr_fin) || $past(wr_fin, 2) || $past(wr_fin, 3))
      else $error("acknowledge without a finished write");
   cover property (any_ack);
   cover property (wr_fin && mem_req_out.byteenable == 4'h8);
   cover property (avs_write_in && !avs_waitrequest_out);
endmodule : dmaac_core_checker
bind dmaac_core dmaac_core_checker #(.CHANNELS(CHANNELS)) u_dmaac_core_checker (
   .core_clk_in(core_clk_in),
   .rst_n_in(rst_n_in),
   .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in),
   .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out),
   .mem_req_out(mem_req_out),
   .mem_waitrequest_in(mem_waitrequest_in),
   .channel_acknowledge_out(channel_acknowledge_out)
);

//--- bench/dmaac_mem_model.sv
// Behavioural system bus memory with a settable number of wait cycles.
`timescale 1ns/1ps
module dmaac_mem_model (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire dmaac_pkg::dmaac_bus_req_s mem_req_in,
   input wire logic [3:0] wait_cycles_in,
   output logic mem_waitrequest_out,
   output logic [31:0] mem_readdata_out,
   output dmaac_pkg::dmaac_bus_req_s last_write_out,
   output logic [7:0] write_count_out
);
   logic [3:0] wait_q;
   logic [31:0] tick_q;
   logic busy;
   assign busy = mem_req_in.read || mem_req_in.write;
   // Reads return the inverted address; between answers the data lines change every
   // cycle, so a stale word can never pass for a fresh one.
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wait_q <= 4'h0;
         tick_q <= 32'h0000_0000;
         mem_waitrequest_out <= 1'b1;
         mem_readdata_out <= 32'h0000_0000;
      end
      else if (busy && mem_waitrequest_out && wait_q == wait_cycles_in)
      begin
         wait_q <= 4'h0;
         mem_waitrequest_out <= 1'b0;
         mem_readdata_out <= ~mem_req_in.address;
      end
      else
      begin
         wait_q <= (busy && mem_waitrequest_out) ? wait_q + 4'h1 : 4'h0;
         tick_q <= tick_q + 32'h0001_0003;
         mem_waitrequest_out <= 1'b1;
         mem_readdata_out <= tick_q;
      end
   end
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         last_write_out <= '0;
         write_count_out <= 8'h00;
      end
      else if (mem_req_in.write && !mem_waitrequest_out)
      begin
         last_write_out <= mem_req_in;
         write_count_out <= write_count_out + 8'h01;
      end
   end
endmodule : dmaac_mem_model

//--- bench/tb_dma_channel_address_count.sv
// Self-checking bench for the DMA channel address and count core.
`timescale 1ns/1ps
`include "dmaac_params.svh"
module tb_dma_channel_address_count;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   dmaac_pkg::dmaac_bus_req_s mem_req;
   dmaac_pkg::dmaac_bus_req_s last_wr;
   logic mem_waitrequest;
   logic [31:0] mem_readdata;
   logic [7:0] dma_request = 8'h00;
   logic [7:0] ack;
   logic [3:0] wait_cycles = 4'h0;
   logic [7:0] wr_count;
   int mismatches = 0;
   int n_compared = 0;
   always #50 core_clk_in = ~core_clk_in;
   dmaac_core u_dmaac_core (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .avs_address_in(avs_address),
      .avs_read_in(avs_read),
      .avs_write_in(avs_write),
      .avs_writedata_in(avs_writedata),
      .avs_byteenable_in(avs_byteenable),
      .avs_readdata_out(avs_readdata),
      .avs_waitrequest_out(avs_waitrequest),
      .mem_req_out(mem_req),
      .mem_waitrequest_in(mem_waitrequest),
      .mem_readdata_in(mem_readdata),
      .dma_request_in(dma_request),
      .channel_acknowledge_out(ack)
   );
   dmaac_mem_model u_dmaac_mem_model (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .mem_req_in(mem_req),
      .wait_cycles_in(wait_cycles),
      .mem_waitrequest_out(mem_waitrequest),
      .mem_readdata_out(mem_readdata),
      .last_write_out(last_wr),
      .write_count_out(wr_count)
   );
   task automatic test_done;
      if (mismatches == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // One Avalon cycle; the extra edge at the end keeps two requests from colliding.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= !wr;
      avs_write <= wr;
      do
      begin
         @(posedge core_clk_in);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50)
         check("register bus answer", 32'h0000_0000, 32'h0000_0001);
      @(posedge core_clk_in);
   endtask : bus
   task automatic wreg(input int ch, input logic [2:0] r, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, {ch[2:0], r, 2'b00}, d, 4'hF, q);
   endtask : wreg
   task automatic rchk(input string nm, input int ch, input logic [2:0] r,
                       input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, {ch[2:0], r, 2'b00}, 32'h0000_0000, 4'hF, q);
      check(nm, q, exp);
   endtask : rchk
   task automatic ptrs(input int ch, input logic [31:0] s, input logic [31:0] d,
                       input logic [23:0] c);
      rchk("source pointer", ch, `DMAAC_OFS_SRC_PTR, s);
      rchk("destination pointer", ch, `DMAAC_OFS_DST_PTR, d);
      rchk("remaining bytes", ch, `DMAAC_OFS_REMAIN, {8'h00, c});
   endtask : ptrs
   task automatic run_xfer(input int ch, input logic [31:0] s, input logic [31:0] d,
                           input logic [23:0] c, input logic [7:0] modes,
                           input logic [7:0] ctrl, input logic pulse);
      int n;
      wreg(ch, `DMAAC_OFS_SRC_PTR, s);
      wreg(ch, `DMAAC_OFS_DST_PTR, d);
      wreg(ch, `DMAAC_OFS_REMAIN, {8'h00, c});
      wreg(ch, `DMAAC_OFS_STEP_CTRL, {24'h00_0000, modes});
      wreg(ch, `DMAAC_OFS_CHAN_CTRL, {24'h00_0000, ctrl});
      dma_request[ch] <= 1'b1;
      if (pulse)
      begin
         @(posedge core_clk_in);
         dma_request[ch] <= 1'b0;
      end
      n = 0;
      do
      begin
         @(posedge core_clk_in);
         n++;
      end while (ack[ch] !== 1'b1 && n < 300);
      check("acknowledge lines", {24'h00_0000, ack}, 32'h0000_0001 << ch);
      dma_request[ch] <= 1'b0;
   endtask : run_xfer
   task automatic t_regs;
      logic [31:0] q;
      wreg(3, `DMAAC_OFS_SRC_PTR, 32'hA5A5_0F0F);
      bus(1'b1, 8'h60, 32'h1234_5678, 4'h2, q);
      rchk("merged source", 3, `DMAAC_OFS_SRC_PTR, 32'hA5A5_560F);
      wreg(3, `DMAAC_OFS_DST_PTR, 32'h8765_4321);
      rchk("destination", 3, `DMAAC_OFS_DST_PTR, 32'h8765_4321);
      wreg(3, `DMAAC_OFS_REMAIN, 32'hFFFF_FFFF);
      rchk("count width", 3, `DMAAC_OFS_REMAIN, 32'h00FF_FFFF);
      wreg(3, 3'h6, 32'hFFFF_FFFF);
      rchk("unmapped six", 3, 3'h6, 32'h0000_0000);
      rchk("unmapped seven", 3, 3'h7, 32'h0000_0000);
   endtask : t_regs
   // Count mode codes one to four, all three sizes and all directions, with slow answers too.
   task automatic t_steps;
      run_xfer(0, 32'h0000_1000, 32'h0000_2000, 16, 8'h0B, 8'h09, 1'b0);
      ptrs(0, 32'h0000_5000, 32'h0000_2040, 12);
      check("write address", last_wr.address, 32'h0000_2000);
      check("write data", last_wr.writedata, 32'hFFFF_EFFF);
      wait_cycles <= 4'h3;
      run_xfer(1, 32'h0000_1000, 32'h0000_2000, 10, 8'h11, 8'h95, 1'b0);
      ptrs(1, 32'h0000_0FE0, 32'h0000_2000, 8);
      check("half lanes", {28'h000_0000, last_wr.byteenable}, 32'h0000_0003);
      wait_cycles <= 4'h1;
      run_xfer(2, 32'h0000_3000, 32'h0005_0123, 3, 8'h24, 8'h41, 1'b0);
      ptrs(2, 32'h0001_3000, 32'h0004_0123, 2);
      check("byte lanes", {28'h000_0000, last_wr.byteenable}, 32'h0000_0008);
      wait_cycles <= 4'h0;
      run_xfer(7, 32'h0000_0ABC, 32'h0000_8000, 24'hFF_FFFF, 8'h1A, 8'h49, 1'b0);
      ptrs(7, 32'h0000_0EBC, 32'h0000_4000, 24'hFF_FFFB);
   endtask : t_steps
   task automatic t_m2m;
      logic [7:0] c0;
      c0 = wr_count;
      wait_cycles <= 4'h2;
      run_xfer(4, 32'h0000_0100, 32'h0000_0200, 12, 8'h00, 8'h0B, 1'b1);
      check("writes before acknowledge", {24'h00_0000, wr_count - c0}, 32'h0000_0003);
      ptrs(4, 32'h0000_010C, 32'h0000_020C, 0);
      check("last write data", last_wr.writedata, 32'hFFFF_FEF7);
      rchk("done flag", 4, `DMAAC_OFS_CHAN_STAT, 32'h0000_0001);
      rchk("start cleared", 4, `DMAAC_OFS_CHAN_CTRL, 32'h0000_000A);
   endtask : t_m2m
   initial
   begin
      repeat (12) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      @(posedge core_clk_in);
      check("idle waitrequest", {31'h0000_0000, avs_waitrequest}, 32'h0000_0001);
      t_regs;
      t_steps;
      t_m2m;
      test_done;
   end
   initial
   begin
      #3_000_000;
      check("watchdog", 32'h0000_0000, 32'h0000_0001);
      test_done;
   end
endmodule : tb_dma_channel_address_count
